// ==== abt_pkg.sv ====
// Constants shared by the break and idle transmitter
package abt_pkg;
  // Frame lengths in bit times
  localparam logic [3:0] FRAME_BITS_SHORT = 4'hA;
  localparam logic [3:0] FRAME_BITS_LONG  = 4'hB;
  // Default baud divider (clk cycles per bit time)
  localparam logic [15:0] BAUD_DIV_RESET = 16'h00D0;
  // Data word width and FIFO depth
  localparam int DATA_W     = 9;
  localparam int FIFO_DEPTH = 16;
  // Transmitter states, one-hot
  typedef enum logic [4:0] {
    ABT_OFF   = 5'b0_0001,
    ABT_READY = 5'b0_0010,
    ABT_IDLE  = 5'b0_0100,
    ABT_BREAK = 5'b0_1000,
    ABT_DATA  = 5'b1_0000
  } abt_state_e;
endpackage

// ==== abt_fifo.sv ====
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module abt_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Honest full and empty from the occupancy count
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end
endmodule

// ==== abt_tx.sv ====
// Break and idle transmitter of the asynchronous serial unit
`timescale 1ns/1ps
module abt_tx (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        transmitter_on,
  input  wire logic        break_request,
  input  wire logic        word_long,
  input  wire logic [15:0] baud_divider,
  input  wire logic [8:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic             tx_out,
  output logic             tx_busy,
  output logic             break_active
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Frame length in bit times for the selected word length
  function automatic logic [3:0] frame_len(input logic long_sel);
    frame_len = long_sel ? abt_pkg::FRAME_BITS_LONG : abt_pkg::FRAME_BITS_SHORT;
  endfunction

  abt_pkg::abt_state_e state_reg;
  logic [15:0]         baud_cnt_reg;
  logic                bit_tick;
  logic [3:0]          bit_cnt_reg;
  logic [3:0]          frame_len_reg;
  logic [10:0]         shift_reg;
  logic                te_prev_reg;
  logic                idle_pend_reg;
  logic                tx_out_reg;
  logic                busy_reg;
  logic                brk_reg;
  logic                fifo_in_ready;
  logic [8:0]          fifo_data;
  logic                fifo_valid;
  logic                fifo_pop;
  logic                fifo_push;
  logic                frame_end;

  // ------------------------------------------------------------
  // Data FIFO
  // ------------------------------------------------------------
  // Back-pressure reaches the source through tx_ready
  abt_fifo #(
    .WIDTH (abt_pkg::DATA_W),
    .DEPTH (abt_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   (tx_data),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // Ready registered so the output comes from a flip-flop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= fifo_in_ready && !(tx_valid && tx_ready);
    end
  end

  // ------------------------------------------------------------
  // Bit-time divider
  // ------------------------------------------------------------
  // Restarted at every frame start so a frame never inherits a partial bit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      baud_cnt_reg <= 16'h0000;
    end else if (state_reg == abt_pkg::ABT_READY || state_reg == abt_pkg::ABT_OFF) begin
      baud_cnt_reg <= 16'h0000;
    end else if (bit_tick) begin
      baud_cnt_reg <= 16'h0000;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 16'h0001;
    end
  end

  // Zero divider treated as one cycle per bit
  assign bit_tick  = (baud_cnt_reg >= baud_divider - 16'h0001) || (baud_divider == 16'h0000);
  assign frame_end = bit_tick && (bit_cnt_reg == frame_len_reg - 4'h1);
  assign fifo_pop  = (state_reg == abt_pkg::ABT_READY) && transmitter_on && !idle_pend_reg
                     && !break_request && fifo_valid;
  // Only a word offered while ready is shown enters; ready gaps one cycle after each take
  assign fifo_push = tx_valid && tx_ready;

  // ------------------------------------------------------------
  // Idle request capture
  // ------------------------------------------------------------
  // Set wins over the clear taken at idle frame start
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      te_prev_reg   <= 1'b0;
      idle_pend_reg <= 1'b0;
    end else begin
      te_prev_reg <= transmitter_on;
      if (transmitter_on && !te_prev_reg) begin
        idle_pend_reg <= 1'b1;
      end else if (state_reg == abt_pkg::ABT_READY) begin
        idle_pend_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Frame sequencer
  // ------------------------------------------------------------
  // Break request is sampled only between frames, so a frame is never
  // stretched and a cleared request cannot start another one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg     <= abt_pkg::ABT_OFF;
      bit_cnt_reg   <= 4'h0;
      frame_len_reg <= abt_pkg::FRAME_BITS_SHORT;
      shift_reg     <= 11'h7FF;
    end else begin
      case (state_reg)
        abt_pkg::ABT_OFF: begin
          if (transmitter_on) begin
            state_reg <= abt_pkg::ABT_READY;
          end
        end
        abt_pkg::ABT_READY: begin
          bit_cnt_reg   <= 4'h0;
          frame_len_reg <= frame_len(word_long);
          if (!transmitter_on) begin
            state_reg <= abt_pkg::ABT_OFF;
          end else if (idle_pend_reg) begin
            state_reg <= abt_pkg::ABT_IDLE;
          end else if (break_request) begin
            state_reg <= abt_pkg::ABT_BREAK;
          end else if (fifo_valid) begin
            state_reg <= abt_pkg::ABT_DATA;
            // Short frames put the stop bit right after eight data bits
            if (word_long) begin
              shift_reg <= {1'b1, fifo_data, 1'b0};
            end else begin
              shift_reg <= {2'b11, fifo_data[7:0], 1'b0};
            end
          end
        end
        abt_pkg::ABT_IDLE, abt_pkg::ABT_BREAK, abt_pkg::ABT_DATA: begin
          if (bit_tick) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shift_reg   <= {1'b1, shift_reg[10:1]};
          end
          if (frame_end) begin
            state_reg <= abt_pkg::ABT_READY;
          end
        end
        default: begin
          state_reg <= abt_pkg::ABT_OFF;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Line and status outputs
  // ------------------------------------------------------------
  // Line is low for the full break frame including stop positions
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_out_reg <= 1'b1;
      busy_reg   <= 1'b0;
      brk_reg    <= 1'b0;
    end else begin
      busy_reg <= (state_reg != abt_pkg::ABT_OFF) && (state_reg != abt_pkg::ABT_READY);
      brk_reg  <= (state_reg == abt_pkg::ABT_BREAK);
      case (state_reg)
        abt_pkg::ABT_BREAK: tx_out_reg <= 1'b0;
        abt_pkg::ABT_DATA:  tx_out_reg <= shift_reg[0];
        default:            tx_out_reg <= 1'b1;
      endcase
    end
  end

  assign tx_out       = tx_out_reg;
  assign tx_busy      = busy_reg;
  assign break_active = brk_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Break frame length in clock cycles
  logic [19:0] brk_len_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      brk_len_reg <= 20'h0_0000;
    end else if (state_reg == abt_pkg::ABT_BREAK) begin
      brk_len_reg <= brk_len_reg + 20'h0_0001;
    end else begin
      brk_len_reg <= 20'h0_0000;
    end
  end

  sequence s_break_start;
    state_reg == abt_pkg::ABT_READY && transmitter_on && !idle_pend_reg && break_request;
  endsequence

  sequence s_enter_break;
    ##1 state_reg == abt_pkg::ABT_BREAK;
  endsequence

  a_break_starts: assert property (@(posedge clk) disable iff (sys_rst)
    s_break_start |-> s_enter_break)
    else $error("break not started on request");

  a_break_no_extra: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == abt_pkg::ABT_READY && !break_request) |=> state_reg != abt_pkg::ABT_BREAK)
    else $error("break started without request");

  a_break_length: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == abt_pkg::ABT_BREAK && frame_end)
      |-> brk_len_reg + 20'h0_0001 == 20'(frame_len_reg) * 20'(baud_divider == 16'h0 ? 16'h1 : baud_divider))
    else $error("break frame length wrong");

  a_break_line_low: assert property (@(posedge clk) disable iff (sys_rst)
    $past(state_reg == abt_pkg::ABT_BREAK) |-> tx_out == 1'b0)
    else $error("line high during break");

  a_line_returns: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == abt_pkg::ABT_BREAK && frame_end) ##1 !break_request |=> tx_out == 1'b1)
    else $error("line not released after break");

  a_idle_first: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == abt_pkg::ABT_READY && transmitter_on && idle_pend_reg)
      |=> state_reg == abt_pkg::ABT_IDLE)
    else $error("idle frame not sent first");

  a_idle_line_high: assert property (@(posedge clk) disable iff (sys_rst)
    $past(state_reg == abt_pkg::ABT_IDLE) |-> tx_out == 1'b1)
    else $error("line low during idle frame");

  a_len_latched: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == abt_pkg::ABT_BREAK |-> (frame_len_reg == abt_pkg::FRAME_BITS_SHORT
      || frame_len_reg == abt_pkg::FRAME_BITS_LONG) && bit_cnt_reg < frame_len_reg)
    else $error("break frame overran");

  // Break cycles allowed for one nominal frame; a doubled break would cross it
  logic [19:0] brk_limit;
  assign brk_limit = 20'(frame_len_reg)
                     * 20'(baud_divider == 16'h0000 ? 16'h0001 : baud_divider);

  // Frame ends, used to chain back-to-back frames
  sequence s_break_end;
    state_reg == abt_pkg::ABT_BREAK && frame_end;
  endsequence

  sequence s_idle_end;
    state_reg == abt_pkg::ABT_IDLE && frame_end;
  endsequence

  a_break_never_long: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == abt_pkg::ABT_BREAK |-> brk_len_reg < brk_limit)
    else $error("break frame stretched");

  a_break_repeats: assert property (@(posedge clk) disable iff (sys_rst)
    s_break_end ##1 s_break_start |-> s_enter_break)
    else $error("held request did not repeat break");

  a_break_ends_ready: assert property (@(posedge clk) disable iff (sys_rst)
    s_break_end |=> state_reg == abt_pkg::ABT_READY)
    else $error("break frame did not end");

  a_break_after_idle: assert property (@(posedge clk) disable iff (sys_rst)
    s_idle_end ##1 s_break_start |-> s_enter_break)
    else $error("break lost after idle frame");

  a_idle_ends_ready: assert property (@(posedge clk) disable iff (sys_rst)
    s_idle_end |=> state_reg == abt_pkg::ABT_READY)
    else $error("idle frame did not end");

  a_break_flag: assert property (@(posedge clk) disable iff (sys_rst)
    break_active == $past(state_reg == abt_pkg::ABT_BREAK))
    else $error("break flag out of step");

  a_busy_in_break: assert property (@(posedge clk) disable iff (sys_rst)
    $past(state_reg == abt_pkg::ABT_BREAK) |-> tx_busy == 1'b1)
    else $error("busy low during break");

  a_len_held: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == abt_pkg::ABT_BREAK && $past(state_reg == abt_pkg::ABT_BREAK)
      |-> $stable(frame_len_reg))
    else $error("frame length changed mid-break");

  a_line_idle_off: assert property (@(posedge clk) disable iff (sys_rst)
    $past(state_reg == abt_pkg::ABT_OFF) |-> tx_out == 1'b1)
    else $error("line low while disabled");
endmodule

// ==== abt_rx_model.sv ====
// Remote asynchronous receiver model on the serial line
`timescale 1ns/1ps
module abt_rx_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        line,
  input  wire logic        word_long,
  input  wire logic [15:0] div,
  output logic [8:0]       rx_word,
  output logic             rx_break,
  output logic [7:0]       rx_count,
  output logic [15:0]      low_run
);
  logic        busy;
  logic        wait_high;
  logic [15:0] ph;
  logic [15:0] run;
  logic [3:0]  bitn;
  logic [10:0] sh;
  // Mid-bit sampler; a low stop bit after all-zero bits means a break; any low stop bit waits for high before rearming
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      wait_high <= 1'b0;
      rx_count <= 8'h00;
      rx_word <= 9'h000;
      rx_break <= 1'b0;
    end else if (!busy) begin
      if (wait_high && line) wait_high <= 1'b0;
      if (!wait_high && !line) begin
        busy <= 1'b1;
        ph <= 16'h0001;
        bitn <= 4'h0;
        sh <= 11'h000;
      end
    end else begin
      ph <= (ph == div - 16'h0001) ? 16'h0000 : ph + 16'h0001;
      if (ph == (div >> 1)) begin
        sh[bitn] <= line;
        bitn <= bitn + 4'h1;
        if (bitn == (word_long ? 4'hA : 4'h9)) begin
          busy <= 1'b0;
          wait_high <= !line;
          rx_count <= rx_count + 8'h01;
          rx_word <= word_long ? sh[9:1] : {1'b0, sh[8:1]};
          rx_break <= !line && (word_long ? sh[9:0] == 0 : sh[8:0] == 0);
        end
      end
    end
  end
  // Length of each low stretch, logged when the line returns high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run <= 16'h0000;
      low_run <= 16'h0000;
    end else if (!line) begin
      run <= run + 16'h0001;
    end else if (run != 0) begin
      low_run <= run;
      run <= 16'h0000;
    end
  end
endmodule

// ==== async_serial_break_idle_tx_test.sv ====
// Self-checking bench for the break and idle transmitter
`timescale 1ns/1ps
module async_serial_break_idle_tx_test;
  localparam logic [15:0] DIV = 16'h0004;
  typedef struct {logic wl; logic [8:0] d;} abt_row_s;
  abt_row_s rows[4] = '{'{1'b0, 9'h055}, '{1'b0, 9'h1A3}, '{1'b1, 9'h1C5}, '{1'b1, 9'h0FF}};
  logic clk, sys_rst, transmitter_on, break_request, word_long, tx_valid, ok, ba_d;
  logic tx_ready, tx_out, tx_busy, break_active, rx_break;
  logic [8:0]  tx_data, rx_word;
  logic [7:0]  rx_count, seen;
  logic [15:0] low_run;
  logic [8:0]  q[$];
  int mismatches, samples_checked, brk_n, b0, n, k;
  abt_tx dut_u (.clk(clk), .sys_rst(sys_rst), .transmitter_on(transmitter_on),
    .break_request(break_request), .word_long(word_long), .baud_divider(DIV),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_out(tx_out),
    .tx_busy(tx_busy), .break_active(break_active));
  abt_rx_model rx_u (.clk(clk), .sys_rst(sys_rst), .line(tx_out), .word_long(word_long),
    .div(DIV), .rx_word(rx_word), .rx_break(rx_break), .rx_count(rx_count),
    .low_run(low_run));
  // Free-running clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Counts break starts and logs received words away from the active edge
  always @(negedge clk) begin
    if (break_active === 1'b1 && ba_d !== 1'b1) brk_n++;
    ba_d = break_active;
    if (rx_count !== seen) begin
      q.push_back(rx_word);
      seen = rx_count;
    end
  end
  task automatic tick(int c);
    repeat (c) @(posedge clk);
    #2;
  endtask
  task automatic err(string m);
    mismatches++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task automatic chk_bit(logic g, logic e);
    samples_checked++;
    if (g !== e) err("flag mismatch");
  endtask
  task automatic chk_val(logic [15:0] g, logic [15:0] e);
    samples_checked++;
    if (g !== e) err($sformatf("value %h expected %h", g, e));
  endtask
  // Valid and data stay put until ready is seen at a falling edge
  task automatic push(logic [8:0] d, int tries);
    tx_data = d;
    tx_valid = 1'b1;
    ok = 1'b0;
    repeat (tries) if (!ok) begin
      @(negedge clk);
      ok = tx_ready;
      tick(1);
    end
  endtask
  task automatic wait_free();
    k = 0;
    while (tx_busy !== 1'b0 && k < 500) begin tick(1); k++; end
    if (k >= 500) err("busy never cleared");
  endtask
  task automatic wait_rx(int t);
    k = 0;
    while (seen !== 8'(t) && k < 2000) begin tick(1); k++; end
    if (k >= 2000) err("receiver timed out");
  endtask
  // Single break; request drops mid-frame so only one may follow
  task automatic brk_once(logic wl);
    word_long = wl;
    b0 = brk_n;
    break_request = 1'b1;
    tick(3);
    break_request = 1'b0;
    wait_free();
    tick(2);
    chk_val(16'(brk_n - b0), 16'h0001);
    chk_val(low_run, DIV * (wl ? abt_pkg::FRAME_BITS_LONG : abt_pkg::FRAME_BITS_SHORT));
    chk_bit(rx_break, 1'b1);
    chk_bit(tx_out, 1'b1);
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run needs about 1400 cycles; allow about fourteen times that
  initial begin
    #(40 * 20000);
    err("watchdog");
    final_report();
  end
  initial begin
    sys_rst = 1'b1; transmitter_on = 1'b0; break_request = 1'b0; word_long = 1'b0;
    tx_valid = 1'b0; tx_data = 9'h000; seen = 8'h00; brk_n = 0;
    tick(5);
    chk_bit(tx_out, 1'b1);
    chk_bit(tx_ready, 1'b0);
    sys_rst = 1'b0;
    tick(2);
    // First enable queues an idle frame: busy with the line high
    transmitter_on = 1'b1;
    tick(4);
    chk_bit(tx_busy, 1'b1);
    chk_bit(tx_out, 1'b1);
    wait_free();
    chk_val(16'(seen), 16'h0000);
    // Table of data frames, short and long words
    foreach (rows[i]) begin
      word_long = rows[i].wl;
      n = seen + 1;
      push(rows[i].d, 50);
      tx_valid = 1'b0;
      wait_rx(n);
      chk_val(16'(q[$]), 16'(rows[i].wl ? rows[i].d : {1'b0, rows[i].d[7:0]}));
      chk_bit(rx_break, 1'b0);
    end
    // Fill the buffer until refused, then drain it in order
    q.delete();
    word_long = 1'b0;
    n = 0;
    ok = 1'b1;
    while (ok && n < 24) begin
      push(9'(n * 5 + 1), 4);
      if (ok) n++;
    end
    tx_valid = 1'b0;
    chk_bit(n >= 16 && n <= 18, 1'b1);
    wait_rx(seen + n);
    for (int i = 0; i < n; i++) chk_val(16'(q[i]), 16'(i * 5 + 1));
    brk_once(1'b0);
    brk_once(1'b1);
    // Held request: breaks repeat, stop after the one in flight
    word_long = 1'b0;
    b0 = brk_n;
    break_request = 1'b1;
    k = 0;
    while (brk_n < b0 + 3 && k < 500) begin tick(1); k++; end
    break_request = 1'b0;
    wait_free();
    tick(2);
    chk_val(16'(brk_n - b0), 16'h0003);
    // Idle request right before a break, nothing in between
    b0 = brk_n;
    transmitter_on = 1'b0;
    tick(1);
    transmitter_on = 1'b1;
    break_request = 1'b1;
    n = 0;
    while (brk_n == b0 && n < 500) begin tick(1); n++; end
    break_request = 1'b0;
    chk_bit(n >= 40, 1'b1);
    wait_free();
    tick(2);
    chk_val(16'(brk_n - b0), 16'h0001);
    chk_val(low_run, DIV * abt_pkg::FRAME_BITS_SHORT);
    // Reset in the middle of a break
    break_request = 1'b1;
    tick(20);
    sys_rst = 1'b1;
    tick(1);
    chk_bit(tx_out, 1'b1);
    chk_bit(tx_busy, 1'b0);
    chk_bit(break_active, 1'b0);
    chk_bit(tx_ready, 1'b0);
    // Release with the enable still high: an idle frame comes first, no break
    b0 = brk_n;
    break_request = 1'b0;
    sys_rst = 1'b0;
    tick(1);
    chk_bit(tx_ready, 1'b1);
    chk_bit(tx_busy, 1'b0);
    tick(2);
    chk_bit(tx_busy, 1'b1);
    chk_bit(tx_out, 1'b1);
    wait_free();
    tick(2);
    chk_val(16'(brk_n - b0), 16'h0000);
    final_report();
  end
endmodule
